// ### hdl/lsu_pkg.sv
// lsu_pkg: shared types and constants of the load/store unit
// assumes a single core clock and a 32-bit internal bus
package lsu_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CNT_W = 8;
  localparam int REG_W = 5;
  localparam int AQ_DEPTH = 2;
  localparam int SQ_DEPTH = 2;
  localparam logic [2:0] LEN_BYTE = 3'h1;
  localparam logic [2:0] LEN_HALF = 3'h2;
  localparam logic [2:0] LEN_WORD = 3'h4;
  localparam logic [3:0] BE_WORD = 4'hF;
  localparam logic [3:0] BE_LO_HALF = 4'h3;
  localparam logic [3:0] BE_HI_HALF = 4'hC;
  localparam logic [3:0] BE_BYTE0 = 4'h1;
  localparam logic [1:0] LANE_ZERO = 2'h0;
  localparam logic [CNT_W-1:0] WORD_BYTES = 8'h04;
  localparam logic [1:0] CNT_ZERO = 2'h0;
  localparam logic [1:0] CNT_ONE = 2'h1;
  localparam logic [1:0] CNT_FULL = 2'h2;

  // single covers byte..double-word; resv is lwarx/stwcx/sync; spr is special-register move
  typedef enum logic [4:0] {
    K_SINGLE = 5'h01,
    K_MULTI = 5'h02,
    K_STRING = 5'h04,
    K_RESV = 5'h08,
    K_SPR = 5'h10
  } kind_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h1,
    S_WAIT = 3'h2,
    S_RUN = 3'h4
  } state_t;

  typedef struct packed {
    logic addr;
    logic src;
    logic dst;
    logic upd;
  } opbusy_t;

  typedef struct packed {
    kind_t kind;
    logic store;
    logic update;
    logic [CNT_W-1:0] count;
    logic [REG_W-1:0] reg_base;
    logic [DATA_W-1:0] wdata_lo;
    logic [DATA_W-1:0] wdata_hi;
  } req_t;

  typedef struct packed {
    kind_t kind;
    logic store;
    logic guarded;
    logic [CNT_W-1:0] count;
    logic [REG_W-1:0] reg_base;
    logic [ADDR_W-1:0] addr;
  } aq_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [3:0] be;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic nonspec;
    logic special;
  } bus_t;
endpackage : lsu_pkg

// ### hdl/lsu_align.sv
// lsu_align: picks the largest naturally aligned piece at a byte lane
// assumes rem is at least one; purely combinational
`timescale 1ns/1ps
`default_nettype none
module lsu_align (
  input wire logic [1:0] lane,
  input wire logic [lsu_pkg::CNT_W-1:0] rem,
  output logic [2:0] len,
  output logic [3:0] be
);
  always_comb
  begin
    if (lane == lsu_pkg::LANE_ZERO && rem >= lsu_pkg::WORD_BYTES)
    begin
      len = lsu_pkg::LEN_WORD;
      be = lsu_pkg::BE_WORD;
    end
    else if (!lane[0] && rem >= {5'h00, lsu_pkg::LEN_HALF})
    begin
      len = lsu_pkg::LEN_HALF;
      be = lane[1] ? lsu_pkg::BE_HI_HALF : lsu_pkg::BE_LO_HALF;
    end
    else
    begin
      len = lsu_pkg::LEN_BYTE;
      be = lsu_pkg::BE_BYTE0 << lane;
    end
  end
endmodule : lsu_align
`default_nettype wire

// ### hdl/lsu_core.sv
// lsu_core: load/store unit between register file, sequencer and internal bus
// assumes one bus cycle outstanding, bus_ack/bus_err from logic on sys_clk
// Function
// - register file data path is 32 bits
// - word load two clocks, double four
// - double-word goes as two bus accesses
// - store latency one clock, done in two
// - one shared two-entry address queue
// - separate two-entry 32-bit store data queue
// - incrementor makes successive addresses, no stall
// - check operand scoreboard before accepting
// - accept, free sequencer, request effective address
// - loads and stores execute in order
// - empty queue goes straight to cache
// - update register written back next clock
// - serialising kinds wait for earlier instructions
// - serialising kinds except special-register moves finish before further issue
// - pieces of one access go back to back
// - store waits for clean termination of earlier
// - one idle clock from load to store
// - nonspeculative one clock after previous termination
// - load-multiple cycles all nonspeculative
// - later pieces may turn nonspeculative; here a piece keeps the bus.nonspec set at launch from S_WAIT
// - guarded region waits until nonspeculative
// - unaligned access split into aligned transfers
`timescale 1ns/1ps
`default_nettype none
module lsu_core (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic iss_valid,
  input wire lsu_pkg::req_t iss_req,
  input wire lsu_pkg::opbusy_t op_busy,
  input wire logic older_clear,
  output logic iss_take,
  output logic sync_hold,
  output logic ea_req,
  input wire logic ea_valid,
  input wire logic [lsu_pkg::ADDR_W-1:0] ea_addr,
  input wire logic ea_guarded,
  output logic upd_we,
  output logic [lsu_pkg::ADDR_W-1:0] upd_data,
  input wire logic md_valid,
  input wire logic [lsu_pkg::DATA_W-1:0] md_data,
  output logic md_ready,
  output lsu_pkg::bus_t bus,
  output logic bus_req,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic [lsu_pkg::DATA_W-1:0] bus_rdata,
  output logic wb_we,
  output logic [lsu_pkg::REG_W-1:0] wb_reg,
  output logic [lsu_pkg::DATA_W-1:0] wb_data,
  output logic term,
  output logic term_exc
);
  function automatic logic drains(input lsu_pkg::kind_t k);
    return k != lsu_pkg::K_SINGLE;
  endfunction : drains

  function automatic logic holds(input lsu_pkg::kind_t k);
    return k == lsu_pkg::K_MULTI || k == lsu_pkg::K_STRING || k == lsu_pkg::K_RESV;
  endfunction : holds

  function automatic logic [31:0] rot_l(input logic [31:0] d, input logic [1:0] s);
    logic [63:0] t;
    t = {d, d} << {s, 3'h0};
    return t[63:32];
  endfunction : rot_l

  function automatic logic [31:0] rot_r(input logic [31:0] d, input logic [1:0] s);
    logic [63:0] t;
    t = {d, d} >> {s, 3'h0};
    return t[31:0];
  endfunction : rot_r

  lsu_pkg::state_t state;
  lsu_pkg::aq_t aq [lsu_pkg::AQ_DEPTH];
  logic [1:0] aq_cnt;
  logic aq_rd;
  logic [lsu_pkg::DATA_W-1:0] sq [lsu_pkg::SQ_DEPTH];
  logic [1:0] sq_cnt;
  logic sq_rd;
  logic sq_wr;
  lsu_pkg::req_t pend;
  logic ea_wait;
  lsu_pkg::aq_t cur;
  logic [lsu_pkg::ADDR_W-1:0] pos_addr;
  logic [lsu_pkg::CNT_W-1:0] pos_rem;
  logic [lsu_pkg::CNT_W-1:0] done;
  logic [lsu_pkg::DATA_W-1:0] ld_acc;
  logic tgap;
  logic lgap;

  logic take;
  logic [1:0] sq_need;
  logic [1:0] sq_push;
  logic sq_pop;
  logic [1:0] next_sq_cnt;
  logic bypass;
  logic aq_push;
  logic aq_pop;
  lsu_pkg::aq_t incoming;
  logic [2:0] len;
  logic [3:0] be;
  logic [2:0] adv_len;
  logic [3:0] adv_be;
  logic [lsu_pkg::ADDR_W-1:0] adv_addr;
  logic [lsu_pkg::CNT_W-1:0] adv_rem;
  logic [lsu_pkg::CNT_W-1:0] adv_done;
  logic [1:0] rot;
  logic [1:0] adv_rot;
  logic word_end;
  logic acked;
  logic last;
  logic nonspec_now;
  logic launch;
  logic go_on;
  logic [lsu_pkg::DATA_W-1:0] merged;
  logic [lsu_pkg::DATA_W-1:0] ld_rot;

  // current piece and the piece after it, from the incrementor
  lsu_align cur_piece (.lane(pos_addr[1:0]), .rem(pos_rem), .len(len), .be(be));
  lsu_align adv_piece (.lane(adv_addr[1:0]), .rem(adv_rem), .len(adv_len), .be(adv_be));

  always_comb
  begin
    adv_addr = pos_addr + {29'h0, len};
    adv_rem = pos_rem - {5'h00, len};
    adv_done = done + {5'h00, len};
    rot = pos_addr[1:0] - done[1:0];
    adv_rot = adv_addr[1:0] - adv_done[1:0];
    acked = state == lsu_pkg::S_RUN && bus_ack;
    last = adv_rem == '0;
    word_end = adv_done[1:0] == lsu_pkg::LANE_ZERO || last;
    ld_rot = rot_r(bus_rdata, rot);
  end

  // byte merge of a load piece into the word being assembled
  for (genvar j = 0; j < 4; j++)
  begin : g_merge
    logic [1:0] jl;
    assign jl = 2'(j);
    assign merged[8*j +: 8] = (jl >= done[1:0] && {1'b0, jl} < {1'b0, done[1:0]} + len)
      ? ld_rot[8*j +: 8] : ld_acc[8*j +: 8];
  end

  // acceptance after scoreboard and ordering checks
  always_comb
  begin
    // single, reservation and special-register stores carry their word in the request
    sq_need = (iss_req.store && !(iss_req.kind inside {lsu_pkg::K_MULTI, lsu_pkg::K_STRING}))
      ? ((iss_req.count > lsu_pkg::WORD_BYTES) ? lsu_pkg::CNT_FULL : lsu_pkg::CNT_ONE) : lsu_pkg::CNT_ZERO;
    take = iss_valid && !ea_wait && !sync_hold && op_busy == '0
      && aq_cnt != lsu_pkg::CNT_FULL && (sq_cnt + sq_need) <= lsu_pkg::CNT_FULL
      && (!drains(iss_req.kind) || (state == lsu_pkg::S_IDLE && aq_cnt == '0
      && sq_cnt == '0 && older_clear));
    sq_push = take ? sq_need : {1'b0, md_valid && md_ready};
    sq_pop = acked && !bus_err && cur.store && word_end;
    next_sq_cnt = sq_cnt + sq_push - {1'b0, sq_pop};
    incoming = '{kind: pend.kind, store: pend.store, guarded: ea_guarded, count: pend.count,
      reg_base: pend.reg_base, addr: ea_addr};
    bypass = state == lsu_pkg::S_IDLE && aq_cnt == '0 && ea_valid && ea_wait;
    aq_push = ea_valid && ea_wait && !bypass;
    aq_pop = state == lsu_pkg::S_IDLE && aq_cnt != '0;
  end

  // launch gating for a waiting piece
  always_comb
  begin
    nonspec_now = (cur.kind == lsu_pkg::K_MULTI) || (older_clear && !tgap);
    if (cur.store)
      launch = older_clear && !lgap && sq_cnt != '0;
    else
      launch = nonspec_now || !cur.guarded;
    go_on = cur.store ? (!word_end || sq_cnt == lsu_pkg::CNT_FULL) : (bus.nonspec || !cur.guarded);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      iss_take <= 1'b0;
      ea_req <= 1'b0;
      ea_wait <= 1'b0;
      pend <= '0;
    end
    else
    begin
      iss_take <= take;
      ea_req <= take;
      if (take)
        pend <= iss_req;
      ea_wait <= take || (ea_wait && !ea_valid);
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
      sync_hold <= 1'b0;
    else if (take && holds(iss_req.kind))
      sync_hold <= 1'b1;
    else if (term || term_exc)
      sync_hold <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      upd_we <= 1'b0;
      upd_data <= '0;
    end
    else
    begin
      upd_we <= ea_valid && ea_wait && pend.update;
      upd_data <= ea_addr;
    end
  end

  // address queue, first in first out
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || term_exc)
    begin
      aq_cnt <= '0;
      aq_rd <= 1'b0;
    end
    else
    begin
      if (aq_push)
        aq[aq_rd ^ aq_cnt[0]] <= incoming;
      if (aq_pop)
        aq_rd <= !aq_rd;
      aq_cnt <= aq_cnt + {1'b0, aq_push} - {1'b0, aq_pop};
    end
  end

  // store data queue
  always_ff @(posedge sys_clk)
  begin
    if (!nrst || term_exc)
    begin
      sq_cnt <= '0;
      sq_rd <= 1'b0;
      sq_wr <= 1'b0;
      md_ready <= 1'b0;
    end
    else
    begin
      if (sq_push != '0)
        sq[sq_wr] <= take ? iss_req.wdata_lo : md_data;
      if (sq_push == lsu_pkg::CNT_FULL)
        sq[!sq_wr] <= iss_req.wdata_hi;
      sq_wr <= sq_wr ^ sq_push[0];
      if (sq_pop)
        sq_rd <= !sq_rd;
      sq_cnt <= next_sq_cnt;
      md_ready <= next_sq_cnt == '0 && sync_hold && cur.store;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      tgap <= 1'b0;
      lgap <= 1'b0;
    end
    else
    begin
      tgap <= acked;
      lgap <= acked && !cur.store;
    end
  end

  // sequencing of bus pieces
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      state <= lsu_pkg::S_IDLE;
      cur <= '0;
      pos_addr <= '0;
      pos_rem <= '0;
      done <= '0;
      bus <= '0;
      bus_req <= 1'b0;
    end
    else
    begin
      unique case (state)
        lsu_pkg::S_IDLE:
          if (aq_pop || bypass)
          begin
            cur <= aq_pop ? aq[aq_rd] : incoming;
            pos_addr <= aq_pop ? aq[aq_rd].addr : incoming.addr;
            pos_rem <= aq_pop ? aq[aq_rd].count : incoming.count;
            done <= '0;
            state <= lsu_pkg::S_WAIT;
          end
        lsu_pkg::S_WAIT:
          if (launch)
          begin
            bus_req <= 1'b1;
            bus.addr <= {pos_addr[lsu_pkg::ADDR_W-1:2], lsu_pkg::LANE_ZERO};
            bus.be <= be;
            bus.write <= cur.store;
            bus.wdata <= rot_l(sq[sq_rd], rot);
            bus.nonspec <= cur.store || nonspec_now;
            bus.special <= cur.kind == lsu_pkg::K_RESV || cur.kind == lsu_pkg::K_SPR;
            state <= lsu_pkg::S_RUN;
          end
        lsu_pkg::S_RUN:
          if (bus_ack)
          begin
            pos_addr <= adv_addr;
            pos_rem <= adv_rem;
            done <= adv_done;
            if (bus_err || last)
            begin
              bus_req <= 1'b0;
              state <= lsu_pkg::S_IDLE;
            end
            else if (go_on)
            begin
              bus.addr <= {adv_addr[lsu_pkg::ADDR_W-1:2], lsu_pkg::LANE_ZERO};
              bus.be <= adv_be;
              bus.wdata <= rot_l(sq[sq_rd ^ sq_pop], adv_rot);
            end
            else
            begin
              bus_req <= 1'b0;
              state <= lsu_pkg::S_WAIT;
            end
          end
      endcase
    end
  end

  // load write-back a word at a time, and termination
  always_ff @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ld_acc <= '0;
      wb_we <= 1'b0;
      wb_reg <= '0;
      wb_data <= '0;
      term <= 1'b0;
      term_exc <= 1'b0;
    end
    else
    begin
      wb_we <= acked && !bus_err && !cur.store && word_end;
      wb_reg <= cur.reg_base + done[6:2];
      wb_data <= merged;
      ld_acc <= (acked && word_end) ? '0 : (acked ? merged : ld_acc);
      term <= acked && !bus_err && last;
      term_exc <= acked && bus_err;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  sequence load_end_s;
    bus_req && bus_ack && !bus.write;
  endsequence
  sequence store_start_s;
    $rose(bus_req) && bus.write;
  endsequence

  take_checks_a: assert property (iss_take |-> $past(op_busy) == '0 && ea_req)
    else $error("accepted with busy operand or no address request");
  update_next_a: assert property (ea_valid && ea_wait && pend.update |=> upd_we && upd_data == $past(ea_addr))
    else $error("update write-back not on next clock");
  load_store_gap_a: assert property (load_end_s |=> !(bus_req && bus.write))
    else $error("store issued right after load termination");
  store_clean_a: assert property (store_start_s |-> $past(older_clear))
    else $error("store issued before earlier instructions cleared");
  guarded_spec_a: assert property (bus_req && !bus.write && cur.guarded |-> bus.nonspec)
    else $error("speculative cycle to guarded region");
  multi_nonspec_a: assert property (bus_req && cur.kind == lsu_pkg::K_MULTI |-> bus.nonspec)
    else $error("multiple-word cycle not nonspeculative");
  aligned_piece_a: assert property (bus_req |-> bus.addr[1:0] == lsu_pkg::LANE_ZERO
    && (bus.be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}))
    else $error("bus piece not naturally aligned");
  sync_block_a: assert property (sync_hold && $past(sync_hold) |-> !iss_take)
    else $error("instruction accepted while serialising one runs");
  burst_a: assert property (bus_req && bus_ack && !bus_err && !last && go_on |=> bus_req)
    else $error("pieces of one access not back to back");
endmodule : lsu_core
`default_nettype wire

// ### bench/cache_model.sv
// cache_model: data cache on the internal bus, acks each request after delay waits
// assumes one bus cycle outstanding and bus_req held until bus_ack
`timescale 1ns/1ps
`default_nettype none
module cache_model (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire lsu_pkg::bus_t bus,
  input wire logic bus_req,
  input wire logic [3:0] delay,
  output logic bus_ack,
  output logic bus_err,
  output logic [31:0] bus_rdata
);
  logic [3:0] cnt;
  // read data toggles outside the ack cycle so stale data never matches
  always @(posedge sys_clk)
  begin
    bus_err <= 1'b0;
    if (!nrst)
    begin
      bus_ack <= 1'b0;
      cnt <= 4'h0;
      bus_rdata <= 32'h0;
    end
    else if (bus_req && !bus_ack && cnt >= delay)
    begin
      bus_ack <= 1'b1;
      cnt <= 4'h0;
      bus_rdata <= bus.write ? ~bus_rdata : {~bus.addr[15:0], bus.addr[15:0]};
    end
    else
    begin
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      if (bus_req && !bus_ack)
        cnt <= cnt + 4'h1;
    end
  end
endmodule : cache_model
`default_nettype wire

// ### bench/tb_top.sv
// tb_top: self-checking bench of the load/store unit against a cache model
// assumes lsu_pkg compiled first; inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct {
    lsu_pkg::kind_t k;
    logic st;
    logic up;
    logic [7:0] n;
    logic [31:0] a;
    int pc;
    int lat;
  } row_t;
  logic sys_clk, nrst, iss_valid, older_clear, ea_valid, ea_guarded, bus_req, bus_ack, bus_err;
  logic iss_take, sync_hold, ea_req, upd_we, md_ready, wb_we, term, term_exc, seen_req, ns_chk;
  logic [31:0] ea_addr, bus_rdata, upd_data, wb_data, cur_a, last_wb, pa;
  logic [4:0] wb_reg;
  logic [3:0] delay, pbe;
  logic [63:0] sd;
  lsu_pkg::req_t iss_req;
  lsu_pkg::opbusy_t op_busy;
  lsu_pkg::bus_t bus;
  int fails, num_checks, cyc, pieces, nbytes, nterm, first_ack, last_ack, req_cyc, term_cyc, rd_ack, j;
  row_t rows [13];

  lsu_core i_lsu_core (.sys_clk(sys_clk), .nrst(nrst), .iss_valid(iss_valid), .iss_req(iss_req),
    .op_busy(op_busy), .older_clear(older_clear), .iss_take(iss_take), .sync_hold(sync_hold),
    .ea_req(ea_req), .ea_valid(ea_valid), .ea_addr(ea_addr), .ea_guarded(ea_guarded), .upd_we(upd_we),
    .upd_data(upd_data), .md_valid(1'b0), .md_data(32'h0), .md_ready(md_ready), .bus(bus),
    .bus_req(bus_req), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata), .wb_we(wb_we),
    .wb_reg(wb_reg), .wb_data(wb_data), .term(term), .term_exc(term_exc));
  cache_model i_cache_model (.sys_clk(sys_clk), .nrst(nrst), .bus(bus), .bus_req(bus_req),
    .delay(delay), .bus_ack(bus_ack), .bus_err(bus_err), .bus_rdata(bus_rdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  function automatic logic [31:0] exp_rd(input logic [31:0] a, input int n);
    logic [31:0] x, w;
    exp_rd = 32'h0;
    for (int b = 0; b < n; b++)
    begin
      x = a + b;
      w = {~x[15:2], 2'h3, x[15:2], 2'h0};
      exp_rd[8*b+:8] = w[8*x[1:0]+:8];
    end
  endfunction : exp_rd

  // bus monitor: counts pieces and checks every transfer as it is acked
  // samples on the falling edge so registered outputs have settled
  always @(negedge sys_clk)
  begin
    cyc++;
    if (bus_req && !seen_req)
    begin
      seen_req = 1'b1;
      req_cyc = cyc;
    end
    if (bus_req && bus.write && cyc - rd_ack < 2)
      chk(cyc - rd_ack, 2);
    if (bus_req && bus_ack)
    begin
      if (pieces == 0)
        first_ack = cyc;
      else
        chk(bus.addr > pa || (bus.addr == pa && bus.be > pbe), 1);
      chk(bus.be inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC, 4'hF}, 1);
      if (ns_chk)
        chk(bus.nonspec, 1);
      for (int l = 0; l < 4; l++)
      begin
        j = bus.addr + l - cur_a;
        if (bus.write && bus.be[l] && j >= 0 && j < 8)
          chk(bus.wdata[8*l+:8], sd[8*j+:8]);
      end
      if (!bus.write)
        rd_ack = cyc;
      pa = bus.addr;
      pbe = bus.be;
      last_ack = cyc;
      pieces++;
      nbytes += $countones(bus.be);
    end
    if (wb_we)
      last_wb = wb_data;
    if (term || term_exc)
    begin
      nterm++;
      term_cyc = cyc;
    end
  end

  task automatic issue(input row_t r, input logic [3:0] bsy, input logic oc, input logic g);
    int i;
    iss_req = '{kind: r.k, store: r.st, update: r.up, count: r.n, reg_base: 5'h03,
      wdata_lo: sd[31:0], wdata_hi: sd[63:32]};
    op_busy = bsy;
    older_clear = oc;
    cur_a = r.a;
    ns_chk = (r.k == lsu_pkg::K_MULTI) || g;
    pieces = 0;
    nbytes = 0;
    seen_req = 1'b0;
    iss_valid = 1'b1;
    if (bsy != 4'h0 || (!oc && r.k != lsu_pkg::K_SINGLE))
    begin
      repeat (6)
      begin
        @(posedge sys_clk);
        #1;
        chk(iss_take, 0);
      end
      op_busy = 4'h0;
      older_clear = 1'b1;
    end
    for (i = 0; i < 40 && iss_take !== 1'b1; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    if (i == 40)
    begin
      fails++;
      end_of_test();
    end
    chk({ea_req, sync_hold}, {1'b1, r.k inside {lsu_pkg::K_MULTI, lsu_pkg::K_STRING, lsu_pkg::K_RESV}});
    iss_valid = 1'b0;
    ea_valid = 1'b1;
    ea_addr = r.a;
    ea_guarded = g;
    @(posedge sys_clk);
    #1;
    ea_valid = 1'b0;
    chk({upd_we, upd_we ? upd_data : 32'h0}, {r.up, r.up ? r.a : 32'h0});
  endtask : issue

  task automatic wait_term(input int n);
    int i;
    for (i = 0; i < 60 && nterm < n; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    if (nterm < n)
    begin
      fails++;
      end_of_test();
    end
    nterm = 0;
  endtask : wait_term

  task automatic hold_chk;
    repeat (8)
    begin
      @(posedge sys_clk);
      #1;
      chk(bus_req, 0);
    end
    older_clear = 1'b1;
    wait_term(1);
  endtask : hold_chk

  initial
  begin
    nrst = 1'b0;
    iss_valid = 1'b0;
    iss_req = '0;
    op_busy = 4'h0;
    older_clear = 1'b1;
    ea_valid = 1'b0;
    ea_addr = 32'h0;
    ea_guarded = 1'b0;
    delay = 4'h0;
    fails = 0;
    num_checks = 0;
    cyc = 0;
    pieces = 0;
    nbytes = 0;
    nterm = 0;
    rd_ack = -10;
    sd = 64'h8877_6655_4433_2211;
    rows = '{'{lsu_pkg::K_SINGLE, 1'b0, 1'b0, 8'h04, 32'h100, 1, 2},
      '{lsu_pkg::K_SINGLE, 1'b1, 1'b0, 8'h04, 32'h104, 1, 2},
      '{lsu_pkg::K_SINGLE, 1'b0, 1'b1, 8'h04, 32'h101, 3, 0},
      '{lsu_pkg::K_SINGLE, 1'b0, 1'b0, 8'h04, 32'h102, 2, 0},
      '{lsu_pkg::K_SINGLE, 1'b1, 1'b0, 8'h04, 32'h103, 3, 0},
      '{lsu_pkg::K_SINGLE, 1'b0, 1'b0, 8'h02, 32'h103, 2, 0},
      '{lsu_pkg::K_SINGLE, 1'b0, 1'b0, 8'h01, 32'h107, 1, 0},
      '{lsu_pkg::K_SINGLE, 1'b0, 1'b0, 8'h08, 32'h200, 2, 0},
      '{lsu_pkg::K_SINGLE, 1'b1, 1'b1, 8'h08, 32'h208, 2, 0},
      '{lsu_pkg::K_MULTI, 1'b0, 1'b0, 8'h08, 32'h300, 2, 0},
      '{lsu_pkg::K_STRING, 1'b0, 1'b0, 8'h03, 32'h311, 2, 0},
      '{lsu_pkg::K_RESV, 1'b0, 1'b0, 8'h04, 32'h320, 1, 0},
      '{lsu_pkg::K_SPR, 1'b1, 1'b0, 8'h04, 32'h330, 1, 0}};
    repeat (3) @(posedge sys_clk);
    #1;
    chk({iss_take, bus_req, term, wb_we, upd_we}, 0);
    @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    @(posedge sys_clk);
    #1;
    chk({iss_take, bus_req, term, wb_we, upd_we}, 0);
    for (int d = 0; d <= 2; d += 2)
    begin
      delay = d[3:0];
      foreach (rows[i])
      begin
        issue(rows[i], 4'h0, 1'b1, 1'b0);
        wait_term(1);
        chk(pieces, rows[i].pc);
        chk(nbytes, rows[i].n);
        if (!rows[i].st && rows[i].n <= 4 && rows[i].k inside {lsu_pkg::K_SINGLE, lsu_pkg::K_RESV})
          chk(last_wb & ~(32'hFFFF_FFFF << 8*rows[i].n), exp_rd(rows[i].a, rows[i].n));
        if (d == 0)
          chk(last_ack - first_ack, 2 * (rows[i].pc - 1));
        if (d == 0 && rows[i].lat != 0)
          chk(term_cyc - req_cyc, rows[i].lat);
      end
    end
    delay = 4'h0;
    issue(rows[2], 4'h0, 1'b1, 1'b0);
    issue(rows[1], 4'h0, 1'b1, 1'b0);
    wait_term(2);
    issue(rows[0], 4'h0, 1'b0, 1'b1);
    hold_chk();
    issue(rows[1], 4'h0, 1'b0, 1'b0);
    hold_chk();
    for (int i = 0; i < 4; i++)
    begin
      issue(rows[0], 4'h1 << i, 1'b1, 1'b0);
      wait_term(1);
    end
    for (int i = 9; i < 13; i++)
    begin
      issue(rows[i], 4'h0, 1'b0, 1'b0);
      wait_term(1);
    end
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
